/* File: verilog/manchester_fieldbus_phy.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Half-bit ticks give one line rate of 31.25 kbit/s.
// - Frames are Manchester coded between start and end delimiters.
// - Frame opens with preamble octets, count from the preamble register; a count of 0 still sends one.
// - Bytes leave most significant bit first.
// - A 16-bit CRC follows the data, before the end delimiter.
// - Outputs are driver enable, line transmit signal and addition signal.
// - Enable and addition share one pin, chosen by control register bit.
// - After a frame the transmitter waits out the interframe gap.
// - Gap timer is loaded at frame end from the sync time register.
// - Receive input is filtered before recovery and decoding.
// - Receive sampling clock is recovered from the filtered signal.
// - Samples on recovered clock are weighted by the decoder polarity flag.
// - Sync time register holds 4 to 32 bit times.
// - Responder ready time equals the interframe gap time.
module manchester_fieldbus_phy
  import fbphy_pkg::*;
#(
  parameter int HALF_BIT = HALF_BIT_CYCLES,
  parameter int FILTER   = FILTER_CYCLES
)(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        lineRxIn,
  output var  logic        lineTxOut,
  output var  logic        rtsAddOut
);
  rx_link_if link ();

  tx_state_e   txState;
  rx_state_e   rxState;
  logic [11:0] baudCnt;
  logic        halfTick;
  logic [1:0]  ctrl;
  logic [7:0]  preambleLen;
  logic [5:0]  syncTime;
  logic [7:0]  holdData;
  logic        holdLast;
  logic        holdFull;
  logic        holdTake;
  logic [15:0] txShift;
  logic [3:0]  txHalf;
  logic [7:0]  preCnt;
  logic [15:0] txCrc;
  logic        lastSent;
  logic        drvEnable;
  logic [6:0]  gapCnt;
  logic        underrun;
  logic [15:0] rxHalves;
  logic [15:0] next_rxHalves;
  logic [3:0]  rxHalf;
  logic [15:0] rxCrc;
  logic [7:0]  rxData;
  logic        rxValid;
  logic        rxByteDone;
  logic        frameOk;
  logic        crcErr;
  logic        codeErr;
  logic [5:0]  sticky;
  logic        apbDone;
  logic        apbWrite;
  logic        txWriteStall;
  logic [31:0] readValue;

  if (HALF_BIT < 4 * FILTER || HALF_BIT > 4095)
  begin : g_check
    $error("manchester_fieldbus_phy: unsupported HALF_BIT");
  end

  rx_front #(
    .HALF_BIT (HALF_BIT),
    .FILTER   (FILTER)
  ) u_rx_front (
    .clk      (clk),
    .reset    (reset),
    .ce       (ce),
    .lineRxIn (lineRxIn),
    .link     (link.front)
  );

  assign halfTick      = ce && baudCnt == 12'(HALF_BIT - 1);
  assign apbDone       = ce && psel && penable && pready;
  assign apbWrite      = apbDone && pwrite;
  assign txWriteStall  = pwrite && paddr == OFS_TXDATA && holdFull && !holdTake;
  assign next_rxHalves = {rxHalves[14:0], link.sampleBit};

  // free-running half-bit divider
  always_ff @(posedge clk)
  begin
    if (reset)
      baudCnt <= '0;
    else if (ce)
      baudCnt <= (baudCnt == 12'(HALF_BIT - 1)) ? 12'h000 : baudCnt + 12'h001;
  end

  // apb: one wait state, more for a transmit data write while the holding byte is full
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else if (ce)
    begin
      pready  <= psel && penable && !pready && !txWriteStall;
      pslverr <= psel && penable && !pready && !txWriteStall && paddr > OFS_RXDATA;
      prdata  <= (psel && !pwrite) ? readValue : 32'h0000_0000;
    end
  end

  always_comb
  begin
    readValue = 32'h0000_0000;
    case (paddr)
      OFS_CTRL:     readValue = {30'h0, ctrl};
      OFS_PREAMBLE: readValue = {24'h0, preambleLen};
      OFS_SYNTIME:  readValue = {26'h0, syncTime};
      OFS_STATUS:
      begin
        readValue[ST_TXBUSY]   = txState != TX_IDLE && txState != TX_GAP;
        readValue[ST_HOLDFULL] = holdFull;
        readValue[ST_GAP]      = gapCnt != 7'h00;
        readValue[ST_RSPRDY]   = gapCnt == 7'h00;
        readValue[ST_RXFRAME]  = rxState == RX_BYTE;
        readValue[ST_POLARITY] = link.polarityFlag;
        readValue[ST_ACTIVITY:ST_FRAMEOK] = sticky;
      end
      OFS_RXDATA:   readValue = {23'h0, rxValid, rxData};
      default:      readValue = 32'h0000_0000;
    endcase
  end

  // configuration registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctrl        <= CTRL_RST;
      preambleLen <= PREAMBLE_RST;
      syncTime    <= SYNTIME_RST;
    end
    else if (apbWrite)
    begin
      if (paddr == OFS_CTRL)
        ctrl <= pwdata[1:0];
      if (paddr == OFS_PREAMBLE)
        preambleLen <= pwdata[7:0];
      if (paddr == OFS_SYNTIME)
        syncTime <= (pwdata[31:0] < 32'(SYNTIME_MIN)) ? SYNTIME_MIN :
                    (pwdata[31:0] > 32'(SYNTIME_MAX)) ? SYNTIME_MAX : pwdata[5:0];
    end
  end

  // transmit holding byte; software is held off while it is full
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      holdData <= '0;
      holdLast <= 1'b0;
      holdFull <= 1'b0;
    end
    else if (ce)
    begin
      if (apbWrite && paddr == OFS_TXDATA)
      begin
        holdData <= pwdata[7:0];
        holdLast <= pwdata[TXDATA_LAST];
        holdFull <= 1'b1;
      end
      else if (holdTake)
        holdFull <= 1'b0;
    end
  end

  assign holdTake = halfTick && txHalf == 4'hf && holdFull && !lastSent &&
                    (txState == TX_SDEL || txState == TX_DATA);

  // transmit sequencer, advancing on half-bit ticks
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      txState   <= TX_IDLE;
      txShift   <= '0;
      txHalf    <= '0;
      preCnt    <= '0;
      txCrc     <= CRC_INIT;
      lastSent  <= 1'b0;
      drvEnable <= 1'b0;
      lineTxOut <= 1'b0;
      underrun  <= 1'b0;
    end
    else if (halfTick)
    begin
      underrun <= 1'b0;
      case (txState)
        TX_IDLE:
          if (holdFull && gapCnt == 7'h00)
          begin
            txState   <= TX_LEAD;
            drvEnable <= 1'b1;
          end
        TX_LEAD:
        begin
          txShift  <= manch(PREAMBLE_OCTET);
          txHalf   <= '0;
          preCnt   <= (preambleLen == 8'h00) ? 8'h00 : preambleLen - 8'h01;
          txCrc    <= CRC_INIT;
          lastSent <= 1'b0;
          txState  <= TX_PREAM;
        end
        TX_PREAM, TX_SDEL, TX_DATA, TX_CRCH, TX_CRCL, TX_EDEL:
        begin
          lineTxOut <= txShift[15];
          txShift   <= {txShift[14:0], 1'b0};
          txHalf    <= txHalf + 4'h1;
          if (txHalf == 4'hf)
          begin
            case (txState)
              TX_PREAM:
                if (preCnt != 8'h00)
                begin
                  preCnt  <= preCnt - 8'h01;
                  txShift <= manch(PREAMBLE_OCTET);
                end
                else
                begin
                  txShift <= SD_HALVES;
                  txState <= TX_SDEL;
                end
              TX_SDEL, TX_DATA:
                if (holdFull && !lastSent)
                begin
                  txShift  <= manch(holdData);
                  txCrc    <= crcByte(txCrc, holdData);
                  lastSent <= holdLast;
                  txState  <= TX_DATA;
                end
                else
                begin
                  // starved frames are closed rather than stretched
                  underrun <= !lastSent;
                  txShift  <= manch(~txCrc[15:8]);
                  txState  <= TX_CRCH;
                end
              TX_CRCH:
              begin
                txShift <= manch(~txCrc[7:0]);
                txState <= TX_CRCL;
              end
              TX_CRCL:
              begin
                txShift <= ED_HALVES;
                txState <= TX_EDEL;
              end
              default:
                txState <= TX_TAIL;
            endcase
          end
        end
        TX_TAIL:
        begin
          lineTxOut <= 1'b0;
          drvEnable <= 1'b0;
          txState   <= TX_GAP;
        end
        TX_GAP:
          if (gapCnt == 7'h00)
            txState <= TX_IDLE;
        default:
          txState <= TX_IDLE;
      endcase
    end
  end

  // interframe gap, also the responder ready time, in half-bit ticks
  always_ff @(posedge clk)
  begin
    if (reset)
      gapCnt <= '0;
    else if (halfTick)
    begin
      if (txState == TX_TAIL)
        gapCnt <= {syncTime, 1'b0};
      else if (gapCnt != 7'h00)
        gapCnt <= gapCnt - 7'h01;
    end
  end

  // shared pin; one cycle behind the line, far inside a half-bit
  always_ff @(posedge clk)
  begin
    if (reset)
      rtsAddOut <= 1'b0;
    else if (ce)
      rtsAddOut <= ctrl[CTRL_ADDSEL] ? (drvEnable && !lineTxOut) : drvEnable;
  end

  // decoder: hunts the start delimiter in either polarity, then octets
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rxState           <= RX_HUNT;
      rxHalves          <= '0;
      rxHalf            <= '0;
      rxCrc             <= CRC_INIT;
      rxByteDone        <= 1'b0;
      frameOk           <= 1'b0;
      crcErr            <= 1'b0;
      codeErr           <= 1'b0;
      link.polarityFlag <= 1'b0;
    end
    else if (ce)
    begin
      rxByteDone <= 1'b0;
      frameOk    <= 1'b0;
      crcErr     <= 1'b0;
      codeErr    <= 1'b0;
      if (link.recoveredRxClock && ctrl[CTRL_RXEN])
      begin
        rxHalves <= next_rxHalves;
        rxHalf   <= rxHalf + 4'h1;
        case (rxState)
          RX_HUNT:
            if (next_rxHalves == SD_HALVES || next_rxHalves == ~SD_HALVES)
            begin
              if (next_rxHalves == ~SD_HALVES)
                link.polarityFlag <= !link.polarityFlag;
              rxState <= RX_BYTE;
              rxHalf  <= '0;
              rxCrc   <= CRC_INIT;
            end
          RX_BYTE:
            if (rxHalf == 4'hf)
            begin
              if (next_rxHalves == ED_HALVES)
              begin
                frameOk <= rxCrc == CRC_RESIDUE;
                crcErr  <= rxCrc != CRC_RESIDUE;
                rxState <= RX_HUNT;
              end
              else if (isManch(next_rxHalves))
              begin
                rxCrc      <= crcByte(rxCrc, demanch(next_rxHalves));
                rxByteDone <= 1'b1;
              end
              else
              begin
                codeErr <= 1'b1;
                rxState <= RX_HUNT;
              end
            end
          default:
            rxState <= RX_HUNT;
        endcase
      end
    end
  end

  // receive byte register; a fresh byte wins over the read that clears it
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rxData  <= '0;
      rxValid <= 1'b0;
    end
    else if (ce)
    begin
      if (rxByteDone)
      begin
        rxData  <= demanch(rxHalves);
        rxValid <= 1'b1;
      end
      else if (apbDone && !pwrite && paddr == OFS_RXDATA)
        rxValid <= 1'b0;
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge clk)
  begin
    if (reset)
      sticky <= '0;
    else if (ce)
      sticky <= (sticky & ~((apbWrite && paddr == OFS_STATUS) ?
                            pwdata[ST_ACTIVITY:ST_FRAMEOK] : 6'h00))
                | {link.recoveredPulse, rxByteDone && rxValid, underrun,
                   codeErr, crcErr, frameOk};
  end

  sequence s_frameEnds;
    halfTick && txState == TX_TAIL;
  endsequence

  property p_gapLoad;
    @(posedge clk) disable iff (reset)
      s_frameEnds |=> gapCnt == {$past(syncTime), 1'b0} && !drvEnable;
  endproperty
  a_gapLoad: assert property (p_gapLoad)
    else $error("gap timer not loaded from sync time at frame end");

  property p_gapHolds;
    @(posedge clk) disable iff (reset)
      (txState == TX_GAP && gapCnt != 7'h00) |=> txState == TX_GAP;
  endproperty
  a_gapHolds: assert property (p_gapHolds)
    else $error("transmitter left the gap early");

  property p_drvBeforePreamble;
    @(posedge clk) disable iff (reset)
      (txState inside {TX_LEAD, TX_PREAM, TX_SDEL, TX_DATA, TX_CRCH, TX_CRCL, TX_EDEL})
        |-> drvEnable;
  endproperty
  a_drvBeforePreamble: assert property (p_drvBeforePreamble)
    else $error("driver enable low while frame is on the line");

  property p_pinSelect;
    @(posedge clk) disable iff (reset)
      ce |=> rtsAddOut == ($past(ctrl[CTRL_ADDSEL]) ?
                           ($past(drvEnable) && !$past(lineTxOut)) : $past(drvEnable));
  endproperty
  a_pinSelect: assert property (p_pinSelect)
    else $error("shared pin does not follow its selected function");

  property p_syncRange;
    @(posedge clk) disable iff (reset)
      syncTime >= SYNTIME_MIN && syncTime <= SYNTIME_MAX;
  endproperty
  a_syncRange: assert property (p_syncRange)
    else $error("sync time outside 4 to 32 bit times");

  sequence s_dataDone;
    halfTick && txHalf == 4'hf && txState == TX_DATA && lastSent;
  endsequence

  property p_crcAfterData;
    @(posedge clk) disable iff (reset)
      s_dataDone |=> txState == TX_CRCH && txShift == manch(~$past(txCrc[15:8]));
  endproperty
  a_crcAfterData: assert property (p_crcAfterData)
    else $error("crc high byte does not follow last data byte");

  property p_msbFirst;
    @(posedge clk) disable iff (reset)
      holdTake |=> txShift[15:14] == ($past(holdData[7]) ? 2'b10 : 2'b01);
  endproperty
  a_msbFirst: assert property (p_msbFirst)
    else $error("first cell of a byte is not its msb");

  property p_baudPeriod;
    @(posedge clk) disable iff (reset)
      halfTick |=> baudCnt == 12'h000 ##1 !halfTick;
  endproperty
  a_baudPeriod: assert property (p_baudPeriod)
    else $error("half-bit divider did not wrap");
endmodule : manchester_fieldbus_phy
`default_nettype wire

/* File: verilog/fbphy_pkg.sv */
`default_nettype none
package fbphy_pkg;
  localparam int CLK_HZ          = 100_000_000;
  localparam int BIT_RATE_HZ     = 31_250;
  localparam int HALF_BIT_CYCLES = CLK_HZ / (2 * BIT_RATE_HZ);
  localparam int FILTER_CYCLES   = 16;

  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_PREAMBLE = 8'h04;
  localparam logic [7:0] OFS_SYNTIME  = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0c;
  localparam logic [7:0] OFS_TXDATA   = 8'h10;
  localparam logic [7:0] OFS_RXDATA   = 8'h14;

  localparam int CTRL_ADDSEL   = 0;
  localparam int CTRL_RXEN     = 1;
  localparam int TXDATA_LAST   = 8;
  localparam int RXDATA_VALID  = 8;
  localparam int ST_TXBUSY     = 0;
  localparam int ST_HOLDFULL   = 1;
  localparam int ST_GAP        = 2;
  localparam int ST_RSPRDY     = 3;
  localparam int ST_RXFRAME    = 4;
  localparam int ST_POLARITY   = 5;
  localparam int ST_FRAMEOK    = 8;
  localparam int ST_CRCERR     = 9;
  localparam int ST_CODEERR    = 10;
  localparam int ST_UNDERRUN   = 11;
  localparam int ST_OVERRUN    = 12;
  localparam int ST_ACTIVITY   = 13;

  localparam logic [1:0] CTRL_RST     = 2'h2;
  localparam logic [7:0] PREAMBLE_RST = 8'h01;
  localparam logic [5:0] SYNTIME_RST  = 6'h08;
  localparam logic [5:0] SYNTIME_MIN  = 6'h04;
  localparam logic [5:0] SYNTIME_MAX  = 6'h20;

  localparam logic [7:0]  PREAMBLE_OCTET = 8'haa;
  localparam logic [15:0] SD_HALVES      = 16'hb24d;
  localparam logic [15:0] ED_HALVES      = 16'hb326;
  localparam logic [15:0] CRC_INIT       = 16'hffff;
  localparam logic [15:0] CRC_POLY       = 16'h1021;
  localparam logic [15:0] CRC_RESIDUE    = 16'h1d0f;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h0, TX_LEAD = 4'h1, TX_PREAM = 4'h2, TX_SDEL = 4'h3, TX_DATA = 4'h4,
    TX_CRCH = 4'h5, TX_CRCL = 4'h6, TX_EDEL = 4'h7, TX_TAIL = 4'h8, TX_GAP = 4'h9
  } tx_state_e;

  typedef enum logic [0:0] {RX_HUNT = 1'b0, RX_BYTE = 1'b1} rx_state_e;

  // one data bit is two half-bit cells: 1 -> high,low ; 0 -> low,high
  function automatic logic [15:0] manch(input logic [7:0] b);
    logic [15:0] h;
    h = '0;
    for (int i = 0; i < 8; i++)
    begin
      h[2*i +: 2] = b[i] ? 2'b10 : 2'b01;
    end
    return h;
  endfunction : manch

  function automatic logic [7:0] demanch(input logic [15:0] h);
    logic [7:0] b;
    b = '0;
    for (int i = 0; i < 8; i++)
    begin
      b[i] = h[2*i+1];
    end
    return b;
  endfunction : demanch

  function automatic logic isManch(input logic [15:0] h);
    return ((h ^ (h >> 1)) & 16'h5555) == 16'h5555;
  endfunction : isManch

  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      r = (r[15] ^ b[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crcByte
endpackage : fbphy_pkg
`default_nettype wire

/* File: verilog/rx_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface rx_link_if;
  logic recoveredRxClock;
  logic recoveredPulse;
  logic sampleBit;
  logic polarityFlag;
  modport front  (output recoveredRxClock, recoveredPulse, sampleBit, input polarityFlag);
  modport decode (input recoveredRxClock, recoveredPulse, sampleBit, output polarityFlag);
endinterface : rx_link_if
`default_nettype wire

/* File: verilog/rx_front.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_front
  import fbphy_pkg::*;
#(
  parameter int HALF_BIT = HALF_BIT_CYCLES,
  parameter int FILTER   = FILTER_CYCLES
)(
  input  wire logic  clk,
  input  wire logic  reset,
  input  wire logic  ce,
  input  wire logic  lineRxIn,
  rx_link_if.front   link
);
  logic [5:0]  stableCnt;
  logic        filtered;
  logic [11:0] phaseCnt;
  logic        edgeSeen;

  if (FILTER < 2 || FILTER > 63 || HALF_BIT < 4 * FILTER || HALF_BIT > 4095)
  begin : g_check
    $error("rx_front: unsupported FILTER or HALF_BIT");
  end

  // glitch filter: level must stand FILTER cycles before it is accepted
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stableCnt <= '0;
      filtered  <= 1'b0;
      edgeSeen  <= 1'b0;
    end
    else if (ce)
    begin
      edgeSeen <= 1'b0;
      if (lineRxIn == filtered)
        stableCnt <= '0;
      else if (stableCnt == 6'(FILTER - 1))
      begin
        filtered  <= lineRxIn;
        stableCnt <= '0;
        edgeSeen  <= 1'b1;
      end
      else
        stableCnt <= stableCnt + 6'h01;
    end
  end

  // every filtered edge is a half-cell boundary; sample mid-cell
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      phaseCnt              <= '0;
      link.recoveredRxClock <= 1'b0;
      link.recoveredPulse   <= 1'b0;
      link.sampleBit        <= 1'b0;
    end
    else if (ce)
    begin
      link.recoveredPulse   <= edgeSeen;
      link.recoveredRxClock <= (phaseCnt == 12'(HALF_BIT / 2 - 1));
      if (phaseCnt == 12'(HALF_BIT / 2 - 1))
        link.sampleBit <= filtered ^ link.polarityFlag;
      if (edgeSeen || phaseCnt == 12'(HALF_BIT - 1))
        phaseCnt <= '0;
      else
        phaseCnt <= phaseCnt + 12'h001;
    end
  end

  property p_filterStable;
    @(posedge clk) disable iff (reset)
      (ce && filtered != $past(filtered)) |-> $past(stableCnt) == 6'(FILTER - 1);
  endproperty
  a_filterStable: assert property (p_filterStable)
    else $error("filtered level changed before input was stable");

  property p_sampleTaken;
    @(posedge clk) disable iff (reset)
      (ce && phaseCnt == 12'(HALF_BIT / 2 - 1)) |=>
        link.recoveredRxClock && link.sampleBit == ($past(filtered) ^ $past(link.polarityFlag));
  endproperty
  a_sampleTaken: assert property (p_sampleTaken)
    else $error("sample not filtered level weighted by polarity");
endmodule : rx_front
`default_nettype wire

/* File: tb/mau_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mau_model (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic drvEn,
  input  wire logic txLine,
  output var  logic rxLine
);
  // undriven medium toggles every cycle; the receive filter has to reject it
  always_ff @(posedge clk)
  begin
    if (reset)
      rxLine <= 1'b0;
    else
      rxLine <= drvEn ? txLine : ~rxLine;
  end
endmodule : mau_model
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fbphy_pkg::*;
  localparam int HB = 64;
  logic        clk, reset, ce, psel, penable, pwrite, addMode, err;
  logic        lineRxIn, lineTxOut, rtsAddOut, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, rnd;
  logic [15:0] crc;
  logic        cells[$];
  int          mismatches, n_checks, cyc, lastCell, k;

  manchester_fieldbus_phy #(.HALF_BIT(HB), .FILTER(16)) dut_u (.clk(clk), .reset(reset),
    .ce(ce), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lineRxIn(lineRxIn), .lineTxOut(lineTxOut), .rtsAddOut(rtsAddOut));
  mau_model mau_u (.clk(clk), .reset(reset), .drvEn(rtsAddOut | addMode),
    .txLine(lineTxOut), .rxLine(lineRxIn));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
    cyc <= cyc + 1;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction : crcStep

  // called just after an edge; ends one edge after release so calls never collide
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 5000);
    if (n >= 5000)
      mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic addByte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      cells.push_back(b[i]);
      cells.push_back(~b[i]);
    end
  endtask : addByte

  task automatic add16(input logic [15:0] h);
    for (int i = 15; i >= 0; i--)
      cells.push_back(h[i]);
  endtask : add16

  // syn > 0: frame follows the previous one at once, so the gap must show
  task automatic send_frame(input logic [7:0] pre, input logic mode, input int nb,
                            input int syn);
    logic [7:0] data[4];
    cells = {};
    crc = CRC_INIT;
    for (int i = 0; i < ((pre == 8'h00) ? 1 : pre); i++)
      addByte(PREAMBLE_OCTET);
    add16(SD_HALVES);
    for (int i = 0; i < nb; i++)
    begin
      rnd = lfsr(rnd);
      data[i] = rnd[7:0];
      addByte(data[i]);
      crc = crcStep(crc, data[i]);
    end
    addByte(~crc[15:8]);
    addByte(~crc[7:0]);
    add16(ED_HALVES);
    apb(1'b1, OFS_PREAMBLE, {24'h000000, pre});
    apb(1'b1, OFS_CTRL, {30'h00000000, 1'b1, mode});
    addMode <= mode;
    fork
      for (int i = 0; i < nb; i++)
        apb(1'b1, OFS_TXDATA, {23'h000000, i == nb - 1, data[i]});
      begin
        k = 0;
        while (lineTxOut !== 1'b1 && k < 20000)
        begin
          @(posedge clk);
          k++;
        end
        if (k >= 20000)
          mismatches++;
        if (syn > 0)
          check(cyc - lastCell >= HB / 2 + 2 * syn * HB, 32'h1);
        repeat (HB / 2) @(posedge clk);
        foreach (cells[i])
        begin
          check(lineTxOut, cells[i]);
          check(rtsAddOut, mode ? !cells[i] : 1'b1);
          lastCell = cyc;
          repeat (HB) @(posedge clk);
        end
      end
    join
    repeat (2 * HB) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    // frame ok, overrun since nothing drained rxdata mid-frame; no crc, code or underrun
    check(rd & 32'h1f00, 32'h1100);
    apb(1'b0, OFS_RXDATA, 32'h0);
    check(rd, {23'h000000, 1'b1, ~crc[7:0]});
    apb(1'b1, OFS_STATUS, 32'h3f00);
    $display("frame test done, %0d bytes", nb);
  endtask : send_frame

  initial
  begin
    reset = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    addMode = 1'b0;
    rnd = 32'd81178;
    cyc = 0;
    lastCell = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    apb(1'b0, OFS_CTRL, 32'h0);
    check(rd, 32'h2);
    apb(1'b0, OFS_PREAMBLE, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, OFS_SYNTIME, 32'h0);
    check(rd, 32'h8);
    apb(1'b0, 8'h18, 32'h0);
    check(err, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, OFS_SYNTIME, 32'h2);
    apb(1'b0, OFS_SYNTIME, 32'h0);
    check(rd, 32'h4);
    apb(1'b1, OFS_SYNTIME, 32'h28);
    apb(1'b0, OFS_SYNTIME, 32'h0);
    check(rd, 32'h20);
    apb(1'b1, OFS_SYNTIME, 32'h4);
    // clock enable low must hold the access off
    ce <= 1'b0;
    fork
      apb(1'b1, OFS_PREAMBLE, 32'h7);
      begin
        repeat (8) @(posedge clk);
        check(pready, 32'h0);
        ce <= 1'b1;
      end
    join
    apb(1'b0, OFS_PREAMBLE, 32'h0);
    check(rd, 32'h7);
    $display("register test done");
    send_frame(8'h00, 1'b0, 1, 0);
    send_frame(8'h02, 1'b1, 3, 4);
    send_frame(8'h01, 1'b0, 2, 4);
    stop_test();
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    stop_test();
  end
endmodule : tb
`default_nettype wire
